// [rtl/pcsc_pkg.sv]
// Constants and carrier types for the bus status / class code register bank.
// Assumes a single 40 MHz bus clock and a synchronous active-high reset.
package pcsc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets in configuration space
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] BUS_STATUS_OFFSET = 8'h06;
  localparam logic [7:0] CLASS_AND_REVISION_OFFSET = 8'h08;

  // ---------------------------------------------------------------
  // Command register field positions and reset
  // ---------------------------------------------------------------
  localparam int CMD_PARITY_RESPONSE_ENABLE_BIT = 6;
  localparam int CMD_SYSTEM_ERROR_ENABLE_BIT = 8;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Status register field positions and reset
  // ---------------------------------------------------------------
  localparam int ST_PARITY_ERROR_DETECTED_BIT = 15;
  localparam int ST_SYSTEM_ERROR_SIGNALED_BIT = 14;
  localparam int ST_MASTER_ABORT_RECEIVED_BIT = 13;
  localparam int ST_TARGET_ABORT_RECEIVED_BIT = 12;
  localparam int ST_TARGET_ABORT_SIGNALED_BIT = 11;
  localparam int ST_DEVSEL_TIMING_LSB = 9;
  localparam int ST_MASTER_DATA_PARITY_FLAG_BIT = 8;
  localparam int ST_BACK_TO_BACK_CAPABLE_BIT = 7;
  localparam int ST_USER_FEATURES_SUPPORTED_BIT = 6;
  localparam int ST_HIGH_SPEED_CAPABLE_BIT = 5;
  localparam int ST_CAPABILITIES_PRESENT_BIT = 4;
  localparam logic [1:0] ST_DEVSEL_TIMING_MEDIUM = 2'h1;
  localparam logic [15:0] BUS_STATUS_RESET = 16'h0210;
  localparam int STICKY_COUNT = 6;

  // ---------------------------------------------------------------
  // Class code field positions and fixed values
  // ---------------------------------------------------------------
  localparam int CLS_BASE_CATEGORY_LSB = 24;
  localparam int CLS_SUBCLASS_LSB = 16;
  localparam int CLS_PROGRAMMING_MODEL_LSB = 8;
  localparam int CLS_SILICON_REVISION_LSB = 0;
  localparam logic [7:0] CLS_BASE_CATEGORY = 8'h0C;
  localparam logic [7:0] CLS_SUBCLASS = 8'h00;
  localparam logic [7:0] CLS_PROGRAMMING_MODEL = 8'h10;

  // ---------------------------------------------------------------
  // Timing: device select asserted on the second edge after address
  // ---------------------------------------------------------------
  localparam logic [1:0] DEVSEL_MEDIUM_DELAY = 2'h2;

  // Bus event pulses from the bus engine, one cycle each
  typedef struct packed {
    logic addr_parity_error;
    logic data_parity_error;
    logic master_abort;
    logic target_abort_received;
    logic target_abort_signaled;
    logic master_data_phase;
  } pcsc_events_t;

  // Configuration access request
  typedef struct packed {
    logic sel;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcsc_cfg_req_t;

endpackage : pcsc_pkg

// [rtl/pcsc_sticky.sv]
// One sticky status flag: set by hardware, cleared by a write of one.
// Assumes set and clear are pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pcsc_sticky (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);

  logic flag;
  logic next_flag;

  // Set beats clear so a same-cycle event is never lost
  always_comb begin
    next_flag = i_set | (flag & ~i_clr);
  end

  // Flag register, cleared on bus reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign o_flag = flag;

endmodule : pcsc_sticky
`default_nettype wire

// [rtl/pcsc_top.sv]
// Bus status and class code / revision registers of the host controller,
// plus the error-signal drivers and device-select timing they report on.
// Assumes bus event pulses arrive on i_clk; the parity error pin is async.
`timescale 1ns/1ps
`default_nettype none

module pcsc_top #(
  parameter logic [7:0] SILICON_REVISION = 8'h5A // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcsc_pkg::pcsc_cfg_req_t i_cfg,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,
  input wire pcsc_pkg::pcsc_events_t i_events,
  input wire logic i_claim,
  input wire logic i_txn_end,
  input wire logic i_parity_error_signal_n,
  output logic o_parity_error_signal_n,
  output logic o_parity_error_signal_oe,
  output logic o_system_error_signal_n,
  output logic o_system_error_signal_oe,
  output logic o_device_select_signal_n,
  output logic o_device_select_signal_oe
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic hit_cmd_dword;
  logic hit_class_dword;
  logic cmd_write;
  logic status_clear_lane;

  // Status shares the dword at 04h with the command register
  assign hit_cmd_dword = i_cfg.addr[7:2] == pcsc_pkg::CMD_OFFSET[7:2];
  assign hit_class_dword = i_cfg.addr[7:2] == pcsc_pkg::CLASS_AND_REVISION_OFFSET[7:2];
  assign cmd_write = i_cfg.sel & i_cfg.we & hit_cmd_dword;
  // All sticky bits sit in the top byte of status, lane 3
  assign status_clear_lane = cmd_write & i_cfg.be[3];

  // ---------------------------------------------------------------
  // Command enables
  // ---------------------------------------------------------------
  logic parity_response_enable;
  logic system_error_enable;
  logic next_parity_response_enable;
  logic next_system_error_enable;

  // Only the two enables feeding the error logic are kept here
  always_comb begin
    next_parity_response_enable = parity_response_enable;
    next_system_error_enable = system_error_enable;
    if (cmd_write && i_cfg.be[0]) begin
      next_parity_response_enable = i_cfg.wdata[pcsc_pkg::CMD_PARITY_RESPONSE_ENABLE_BIT];
    end
    if (cmd_write && i_cfg.be[1]) begin
      next_system_error_enable = i_cfg.wdata[pcsc_pkg::CMD_SYSTEM_ERROR_ENABLE_BIT];
    end
  end

  // Enables clear on reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      parity_response_enable <= pcsc_pkg::CMD_RESET[pcsc_pkg::CMD_PARITY_RESPONSE_ENABLE_BIT];
      system_error_enable <= pcsc_pkg::CMD_RESET[pcsc_pkg::CMD_SYSTEM_ERROR_ENABLE_BIT];
    end else begin
      parity_response_enable <= next_parity_response_enable;
      system_error_enable <= next_system_error_enable;
    end
  end

  // ---------------------------------------------------------------
  // Parity error pin synchroniser and master-phase alignment
  // ---------------------------------------------------------------
  logic perr_meta_n;
  logic perr_sync_n;
  logic [1:0] master_phase_dly;
  logic next_perr_meta_n;
  logic next_perr_sync_n;
  logic [1:0] next_master_phase_dly;

  // Master flag delayed two edges to line up with the synced pin
  always_comb begin
    next_perr_meta_n = i_parity_error_signal_n;
    next_perr_sync_n = perr_meta_n;
    next_master_phase_dly = {master_phase_dly[0], i_events.master_data_phase};
  end

  // Pin idles high, so reset to the inactive level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      perr_meta_n <= 1'b1;
      perr_sync_n <= 1'b1;
      master_phase_dly <= 2'h0;
    end else begin
      perr_meta_n <= next_perr_meta_n;
      perr_sync_n <= next_perr_sync_n;
      master_phase_dly <= next_master_phase_dly;
    end
  end

  // ---------------------------------------------------------------
  // Error signal drivers
  // ---------------------------------------------------------------
  logic serr_drive;
  logic perr_drive;
  logic next_serr_drive;
  logic next_perr_drive;

  // Drivers stay off unless the matching enable is set
  always_comb begin
    next_serr_drive = i_events.addr_parity_error & system_error_enable;
    next_perr_drive = i_events.data_parity_error & parity_response_enable;
  end

  // One-cycle low pulses on the shared open-drain lines
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      serr_drive <= 1'b0;
      perr_drive <= 1'b0;
    end else begin
      serr_drive <= next_serr_drive;
      perr_drive <= next_perr_drive;
    end
  end

  assign o_system_error_signal_n = 1'b0;
  assign o_system_error_signal_oe = serr_drive;
  assign o_parity_error_signal_n = 1'b0;
  assign o_parity_error_signal_oe = perr_drive;

  // ---------------------------------------------------------------
  // Device select timing
  // ---------------------------------------------------------------
  logic [1:0] devsel_count;
  logic devsel_active;
  logic [1:0] next_devsel_count;
  logic next_devsel_active;

  // Claim waits the medium delay, then holds until the transfer ends
  always_comb begin
    next_devsel_count = devsel_count;
    next_devsel_active = devsel_active;
    if (i_txn_end) begin
      next_devsel_count = 2'h0;
      next_devsel_active = 1'b0;
    end else if (i_claim) begin
      next_devsel_count = 2'h1;
    end else if (devsel_count != 2'h0) begin
      if (devsel_count == pcsc_pkg::DEVSEL_MEDIUM_DELAY - 2'h1) begin
        next_devsel_count = 2'h0;
        next_devsel_active = 1'b1;
      end else begin
        next_devsel_count = devsel_count + 2'h1;
      end
    end
  end

  // Select released on reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      devsel_count <= 2'h0;
      devsel_active <= 1'b0;
    end else begin
      devsel_count <= next_devsel_count;
      devsel_active <= next_devsel_active;
    end
  end

  assign o_device_select_signal_n = 1'b0;
  assign o_device_select_signal_oe = devsel_active;

  // ---------------------------------------------------------------
  // Sticky status bits
  // ---------------------------------------------------------------
  logic [pcsc_pkg::STICKY_COUNT-1:0] sticky_set;
  logic [pcsc_pkg::STICKY_COUNT-1:0] sticky_clr;
  logic [pcsc_pkg::STICKY_COUNT-1:0] sticky_flag;

  // Event order: 15, 14, 13, 12, 11, 8
  assign sticky_set[5] = i_events.addr_parity_error | i_events.data_parity_error;
  assign sticky_set[4] = serr_drive;
  assign sticky_set[3] = i_events.master_abort;
  assign sticky_set[2] = i_events.target_abort_received;
  assign sticky_set[1] = i_events.target_abort_signaled;
  assign sticky_set[0] = ~perr_sync_n & master_phase_dly[1] & parity_response_enable;

  // Write-one-to-clear, taken from the status half of the dword
  assign sticky_clr[5] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_PARITY_ERROR_DETECTED_BIT];
  assign sticky_clr[4] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_SYSTEM_ERROR_SIGNALED_BIT];
  assign sticky_clr[3] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_MASTER_ABORT_RECEIVED_BIT];
  assign sticky_clr[2] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_TARGET_ABORT_RECEIVED_BIT];
  assign sticky_clr[1] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_TARGET_ABORT_SIGNALED_BIT];
  assign sticky_clr[0] = status_clear_lane
    & i_cfg.wdata[16 + pcsc_pkg::ST_MASTER_DATA_PARITY_FLAG_BIT];

  // One flop per flag; the leaf owns the set-beats-clear ordering
  for (genvar g = 0; g < pcsc_pkg::STICKY_COUNT; g++) begin : g_sticky
    pcsc_sticky u_sticky (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_set(sticky_set[g]),
      .i_clr(sticky_clr[g]),
      .o_flag(sticky_flag[g])
    );
  end

  // ---------------------------------------------------------------
  // Register images
  // ---------------------------------------------------------------
  logic [15:0] bus_status;
  logic [15:0] cmd_image;
  logic [31:0] class_and_revision;

  // Hardwired fields start from the reset image, which already holds
  // devsel 01b and the capability bit
  always_comb begin
    bus_status = pcsc_pkg::BUS_STATUS_RESET;
    bus_status[pcsc_pkg::ST_DEVSEL_TIMING_LSB +: 2] = pcsc_pkg::ST_DEVSEL_TIMING_MEDIUM;
    bus_status[pcsc_pkg::ST_BACK_TO_BACK_CAPABLE_BIT] = 1'b0;
    bus_status[pcsc_pkg::ST_USER_FEATURES_SUPPORTED_BIT] = 1'b0;
    bus_status[pcsc_pkg::ST_HIGH_SPEED_CAPABLE_BIT] = 1'b0;
    bus_status[pcsc_pkg::ST_CAPABILITIES_PRESENT_BIT] = 1'b1;
    bus_status[3:0] = 4'h0;
    bus_status[pcsc_pkg::ST_PARITY_ERROR_DETECTED_BIT] = sticky_flag[5];
    bus_status[pcsc_pkg::ST_SYSTEM_ERROR_SIGNALED_BIT] = sticky_flag[4];
    bus_status[pcsc_pkg::ST_MASTER_ABORT_RECEIVED_BIT] = sticky_flag[3];
    bus_status[pcsc_pkg::ST_TARGET_ABORT_RECEIVED_BIT] = sticky_flag[2];
    bus_status[pcsc_pkg::ST_TARGET_ABORT_SIGNALED_BIT] = sticky_flag[1];
    bus_status[pcsc_pkg::ST_MASTER_DATA_PARITY_FLAG_BIT] = sticky_flag[0];
  end

  // Command bits outside this block read zero
  always_comb begin
    cmd_image = 16'h0000;
    cmd_image[pcsc_pkg::CMD_PARITY_RESPONSE_ENABLE_BIT] = parity_response_enable;
    cmd_image[pcsc_pkg::CMD_SYSTEM_ERROR_ENABLE_BIT] = system_error_enable;
  end

  // Fixed classification and revision
  always_comb begin
    class_and_revision = 32'h0000_0000;
    class_and_revision[pcsc_pkg::CLS_BASE_CATEGORY_LSB +: 8] = pcsc_pkg::CLS_BASE_CATEGORY;
    class_and_revision[pcsc_pkg::CLS_SUBCLASS_LSB +: 8] = pcsc_pkg::CLS_SUBCLASS;
    class_and_revision[pcsc_pkg::CLS_PROGRAMMING_MODEL_LSB +: 8] =
      pcsc_pkg::CLS_PROGRAMMING_MODEL;
    class_and_revision[pcsc_pkg::CLS_SILICON_REVISION_LSB +: 8] = SILICON_REVISION;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic ack;
  logic [31:0] next_rdata;
  logic next_ack;

  // Registered read data; unmapped dwords answer zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_ack = i_cfg.sel;
    if (i_cfg.sel && !i_cfg.we) begin
      if (hit_cmd_dword) begin
        next_rdata = {bus_status, cmd_image};
      end else if (hit_class_dword) begin
        next_rdata = class_and_revision;
      end
    end
  end

  // Data shows the state before any same-cycle write takes effect
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  assign o_cfg_rdata = rdata;
  assign o_cfg_ack = ack;

endmodule : pcsc_top
`default_nettype wire

// [tb/pcsc_top_monitor.sv]
// Checker for the status / class code bank, watching top ports only.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pcsc_top_monitor #(
  parameter logic [7:0] SILICON_REVISION = 8'h5A
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcsc_pkg::pcsc_cfg_req_t i_cfg,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_ack,
  input wire pcsc_pkg::pcsc_events_t i_events,
  input wire logic i_claim,
  input wire logic i_txn_end,
  input wire logic o_parity_error_signal_oe,
  input wire logic o_system_error_signal_oe,
  input wire logic o_device_select_signal_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // -------------------------------------------------------------
  // Access sequences
  // -------------------------------------------------------------
  sequence s_rd_st;
    i_cfg.sel && !i_cfg.we && i_cfg.addr[7:2] == 6'h01;
  endsequence
  sequence s_rd_cls;
    i_cfg.sel && !i_cfg.we && i_cfg.addr[7:2] == 6'h02;
  endsequence
  // Idle cycle, so no clear can sneak in before the read
  sequence s_gap_rd;
    !i_cfg.sel ##1 s_rd_st;
  endsequence
  sequence s_clr;
    // No parity event alongside, since a same-cycle set beats the clear
    i_cfg.sel && i_cfg.we && i_cfg.addr[7:2] == 6'h01 && i_cfg.be[3] && i_cfg.wdata[31]
      && !i_events.addr_parity_error && !i_events.data_parity_error;
  endsequence
  property p_ack;
    i_cfg.sel |=> o_cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_class;
    s_rd_cls |=> o_cfg_rdata == {8'h0C, 8'h00, 8'h10, SILICON_REVISION};
  endproperty
  a_class: assert property (p_class) else $error("class word wrong");
  property p_fixed;
    s_rd_st |=> {o_cfg_rdata[26:25], o_cfg_rdata[23:16]} == 10'h110;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
  property p_par;
    (i_events.addr_parity_error || i_events.data_parity_error) ##1 s_gap_rd |=> o_cfg_rdata[31];
  endproperty
  a_par: assert property (p_par) else $error("parity flag not set");
  property p_mab;
    i_events.master_abort ##1 s_gap_rd |=> o_cfg_rdata[29];
  endproperty
  a_mab: assert property (p_mab) else $error("master abort flag not set");
  property p_tar;
    i_events.target_abort_received ##1 s_gap_rd |=> o_cfg_rdata[28];
  endproperty
  a_tar: assert property (p_tar) else $error("received abort flag not set");
  property p_tas;
    i_events.target_abort_signaled ##1 s_gap_rd |=> o_cfg_rdata[27];
  endproperty
  a_tas: assert property (p_tas) else $error("signaled abort flag not set");
  property p_serr_flag;
    o_system_error_signal_oe ##1 s_rd_st |=> o_cfg_rdata[30];
  endproperty
  a_serr_flag: assert property (p_serr_flag) else $error("system error flag not set");
  property p_serr_src;
    $rose(o_system_error_signal_oe) |-> $past(i_events.addr_parity_error);
  endproperty
  a_serr_src: assert property (p_serr_src) else $error("system error without cause");
  property p_perr_src;
    $rose(o_parity_error_signal_oe) |->
      $past(i_events.data_parity_error || i_events.addr_parity_error);
  endproperty
  a_perr_src: assert property (p_perr_src) else $error("parity drive without cause");
  property p_clr;
    s_clr ##1 (!i_cfg.sel && !i_events.addr_parity_error && !i_events.data_parity_error)
      ##1 s_rd_st |=> !o_cfg_rdata[31];
  endproperty
  a_clr: assert property (p_clr) else $error("write one did not clear");
  property p_dev_on;
    i_claim && !i_txn_end ##1 !i_txn_end && !i_claim |=> o_device_select_signal_oe;
  endproperty
  a_dev_on: assert property (p_dev_on) else $error("device select late");
  property p_dev_off;
    i_txn_end |=> !o_device_select_signal_oe;
  endproperty
  a_dev_off: assert property (p_dev_off) else $error("device select held");
endmodule : pcsc_top_monitor
bind pcsc_top pcsc_top_monitor #(.SILICON_REVISION(SILICON_REVISION)) mon_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_ack(o_cfg_ack), .i_events(i_events), .i_claim(i_claim), .i_txn_end(i_txn_end),
  .o_parity_error_signal_oe(o_parity_error_signal_oe),
  .o_system_error_signal_oe(o_system_error_signal_oe),
  .o_device_select_signal_oe(o_device_select_signal_oe));
`default_nettype wire

// [tb/pcsc_bus_agent.sv]
// Far-side bus agent: reports data parity errors on the shared error pin.
// Assumes the pin has a pull-up; the device drives it through its enable.
`timescale 1ns/1ps
`default_nettype none
module pcsc_bus_agent (
  input wire logic i_report,
  input wire logic i_dev_oe,
  input wire logic i_dev_n,
  output logic o_pin_n
);
  // Wired pin: pull-up unless either party pulls low
  assign o_pin_n = !(i_report || (i_dev_oe && !i_dev_n));
endmodule : pcsc_bus_agent
`default_nettype wire

// [tb/pcsc_top_tb.sv]
// Self-checking bench for the status / class code register bank.
// Assumes the checker is bound to the top by its own file.
`timescale 1ns/1ps
`default_nettype none
module pcsc_top_tb;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision
  // Packed tables, index 0 leftmost, for simulators without array parameters
  localparam logic [0:4][5:0] EV = {6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
  localparam logic [0:4][15:0] MASK = {16'hC000, 16'h8000, 16'h2000, 16'h1000, 16'h0800};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  pcsc_pkg::pcsc_cfg_req_t i_cfg = '0;
  pcsc_pkg::pcsc_events_t i_events = '0;
  logic i_claim = 1'b0;
  logic i_txn_end = 1'b0;
  logic report = 1'b0;
  logic pin_n, ack, perr_n, perr_oe, serr_n, serr_oe, dsel_n, dsel_oe;
  logic seen_perr, seen_serr;
  logic [31:0] rd_w, rdata;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  pcsc_top #(.SILICON_REVISION(REV)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .o_cfg_rdata(rd_w), .o_cfg_ack(ack),
    .i_events(i_events), .i_claim(i_claim), .i_txn_end(i_txn_end),
    .i_parity_error_signal_n(pin_n), .o_parity_error_signal_n(perr_n),
    .o_parity_error_signal_oe(perr_oe), .o_system_error_signal_n(serr_n),
    .o_system_error_signal_oe(serr_oe), .o_device_select_signal_n(dsel_n),
    .o_device_select_signal_oe(dsel_oe));
  pcsc_bus_agent agent_u (.i_report(report), .i_dev_oe(perr_oe), .i_dev_n(perr_n),
    .o_pin_n(pin_n));
  // 40 MHz clock
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Hang guard, far above the roughly 130 cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One access, then an idle cycle so drivers never switch twice at once
  task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    i_cfg = '{1'b1, we, a, be, wd};
    @(posedge i_clk);
    #2 i_cfg.sel = 1'b0;
    rdata = rd_w;
    check({31'h0, ack}, 32'h1);
    @(posedge i_clk);
    #2;
  endtask : cfg
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'h0, 32'h0);
    check(rdata, exp);
  endtask : rd
  // One-cycle event pulse; enables sampled while they stand
  task automatic ev(input logic [5:0] v);
    i_events = v;
    @(posedge i_clk);
    #2 i_events = '0;
    seen_perr = perr_oe;
    seen_serr = serr_oe;
    @(posedge i_clk);
    #2;
  endtask : ev
  task automatic dpar(input logic m, input logic [31:0] exp);
    report = 1'b1;
    i_events.master_data_phase = m;
    @(posedge i_clk);
    #2 report = 1'b0;
    i_events.master_data_phase = 1'b0;
    repeat (3) @(posedge i_clk);
    #2 rd(8'h04, exp);
  endtask : dpar
  initial begin
    repeat (5) @(posedge i_clk);
    #2 i_rst = 1'b0;
    rd(8'h04, 32'h0210_0000);
    rd(8'h08, {8'h0C, 8'h00, 8'h10, REV});
    rd(8'h40, 32'h0);
    cfg(1'b1, 8'h08, 4'hF, '1);
    rd(8'h08, {8'h0C, 8'h00, 8'h10, REV});
    cfg(1'b1, 8'h04, 4'hF, '1);
    rd(8'h04, 32'h0210_0140);
    for (int i = 0; i < 5; i++) begin
      ev(EV[i]);
      check({31'h0, seen_serr}, {31'h0, i == 0});
      if (i == 1) check({31'h0, seen_perr}, 32'h1);
      rd(8'h04, {16'h0210 | MASK[i], 16'h0140});
      cfg(1'b1, 8'h04, 4'h8, 32'h0);
      cfg(1'b1, 8'h04, 4'h4, 32'hFFFF_0000);
      rd(8'h04, {16'h0210 | MASK[i], 16'h0140});
      cfg(1'b1, 8'h04, 4'hC, 32'hFFFF_0000);
      rd(8'h04, 32'h0210_0140);
    end
    cfg(1'b1, 8'h04, 4'h3, 32'h0);
    ev(6'h30);
    check({30'h0, seen_serr, seen_perr}, 32'h0);
    check({30'h0, serr_n, perr_n}, 32'h0);
    rd(8'h04, 32'h8210_0000);
    cfg(1'b1, 8'h04, 4'hC, 32'hFFFF_0000);
    dpar(1'b1, 32'h0210_0000);
    cfg(1'b1, 8'h04, 4'h3, 32'h0000_0140);
    dpar(1'b0, 32'h0210_0140);
    dpar(1'b1, 32'h0310_0140);
    fork
      ev(6'h08);
      cfg(1'b1, 8'h04, 4'hC, 32'hFFFF_0000);
    join
    rd(8'h04, 32'h2210_0140);
    // Mid-run reset must drop the sticky flag and both enables
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #2 i_rst = 1'b0;
    rd(8'h04, 32'h0210_0000);
    i_claim = 1'b1;
    @(posedge i_clk);
    #2 i_claim = 1'b0;
    check({31'h0, dsel_oe}, 32'h0);
    @(posedge i_clk);
    #2 check({30'h0, dsel_oe, dsel_n}, 32'h2);
    repeat (3) @(posedge i_clk);
    #2 i_txn_end = 1'b1;
    @(posedge i_clk);
    #2 i_txn_end = 1'b0;
    check({31'h0, dsel_oe}, 32'h0);
    end_of_test();
  end
endmodule : pcsc_top_tb
`default_nettype wire
